// file: nvac_bench.sv
`timescale 1ns/1ps
module nvac_bench;
  import nvac_pkg::*;
  localparam int unsigned TK = 4;
  localparam int unsigned NA = 6 * TK;
  localparam int unsigned NS = 3 * TK;
  logic       mclk      = 1'b0;
  logic       resetn    = 1'b0;
  logic       porResetn = 1'b0;
  logic [1:0] swAddr    = 2'h0;
  logic [7:0] swWdata   = 8'h00;
  logic       swWr      = 1'b0;
  logic       swRd      = 1'b0;
  logic [7:0] swRdata;
  logic       cpuIrq;
  logic [7:0] last;
  int         n_mismatch = 0;
  int         n_checks   = 0;

  nvac_if bus ();
  // shortened tick keeps each program to a few dozen cycles
  nvac_device #(.TICK_CYCLES(TK), .ATOMIC_TICKS(6), .SPLIT_TICKS(3)) nvac_device_inst (
    .mclk(mclk), .resetn(resetn), .porResetn(porResetn), .io(bus));
  nvac_host nvac_host_inst (.mclk(mclk), .resetn(resetn), .swAddr(swAddr), .swWdata(swWdata),
    .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .cpuIrq(cpuIrq), .io(bus));
  nvac_checker nvac_checker_inst (.mclk(mclk), .resetn(resetn), .ioAddr(bus.ioAddr), .ioWdata(bus.ioWdata),
    .ioWr(bus.ioWr), .ioRd(bus.ioRd), .ioRdata(bus.ioRdata), .cpuStall(bus.cpuStall),
    .readyIrq(bus.readyIrq), .globalIrqEn(bus.globalIrqEn));

  // free-running clock
  always #5 mclk = ~mclk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    swAddr  <= a;
    swWdata <= d;
    swWr    <= 1'b1;
    @(posedge mclk);
    swWr <= 1'b0;
  endtask

  task automatic rdRaw(input logic [1:0] a);
    @(posedge mclk);
    swAddr <= a;
    swRd   <= 1'b1;
    @(posedge mclk);
    swRd <= 1'b0;
    #1;
    last = swRdata;
  endtask

  task automatic rdChk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    rdRaw(a);
    chk(last & m, e);
  endtask

  // arm then start two cycles later, then sit out the stall
  task automatic prog(input logic [7:0] a, input logic [7:0] d, input logic [1:0] m);
    wr(OFS_ADDR, a);
    wr(OFS_DATA, d);
    wr(OFS_CTRL, {2'h0, m, 4'h4});
    wr(OFS_CTRL, {2'h0, m, 4'h6});
    repeat (2) @(posedge mclk);
  endtask

  // busy must still stand two cycles before the end and be gone just after
  task automatic waitDone(input int n);
    repeat (n - 6) @(posedge mclk);
    rdChk(OFS_CTRL, 8'h02, 8'h02);
    repeat (3) @(posedge mclk);
    rdChk(OFS_CTRL, 8'h02, 8'h00);
  endtask

  // bounded poll of the busy bit
  task automatic waitIdle();
    int i;
    i = 0;
    do begin
      rdRaw(OFS_CTRL);
      i++;
    end while (last[BIT_START] !== 1'b0 && i < 40);
  endtask

  task automatic fetch(input logic [7:0] a, input logic [7:0] e);
    wr(OFS_ADDR, a);
    wr(OFS_CTRL, 8'h01);
    repeat (4) @(posedge mclk);
    rdChk(OFS_DATA, 8'hFF, e);
  endtask

  task automatic pulseReset();
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // the sequence needs a few hundred cycles
  initial begin
    #50000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge mclk);
    resetn    <= 1'b1;
    porResetn <= 1'b1;
    wr(OFS_ADDR, 8'hFF);
    rdChk(OFS_ADDR, 8'hFF, 8'h7F);
    wr(OFS_HOST, 8'h01);
    wr(OFS_CTRL, 8'h09);
    repeat (4) @(posedge mclk);
    rdChk(OFS_CTRL, 8'hFF, 8'h08);
    chk({7'h0, cpuIrq}, 8'h01);
    // atomic program, then poke at the block while it is busy
    wr(OFS_ADDR, 8'h05);
    wr(OFS_DATA, 8'h3C);
    wr(OFS_CTRL, 8'h0C);
    wr(OFS_CTRL, 8'h0E);
    wr(OFS_ADDR, 8'h09);
    wr(OFS_ADDR, 8'h11);
    wr(OFS_CTRL, 8'h19);
    rdChk(OFS_CTRL, 8'hFF, 8'h0A);
    rdChk(OFS_ADDR, 8'hFF, 8'h05);
    rdChk(OFS_DATA, 8'hFF, 8'h3C);
    rdChk(OFS_HOST, 8'h0F, 8'h09);
    chk({7'h0, cpuIrq}, 8'h00);
    waitIdle();
    chk(last & 8'h02, 8'h00);
    wr(OFS_HOST, 8'h09);
    repeat (3) @(posedge mclk);
    chk({7'h0, cpuIrq}, 8'h01);
    fetch(8'h05, 8'h3C);
    // every mode code, the reserved one refused
    prog(8'h06, 8'hA5, MODE_ATOMIC);
    waitDone(NA);
    prog(8'h05, 8'h00, MODE_ERASE);
    waitDone(NS);
    fetch(8'h05, ERASED_BYTE);
    fetch(8'h06, 8'hA5);
    prog(8'h05, 8'h5A, MODE_WRITE);
    waitDone(NS);
    fetch(8'h05, 8'h5A);
    prog(8'h05, 8'h00, MODE_RSVD);
    rdChk(OFS_CTRL, 8'h02, 8'h00);
    fetch(8'h05, 8'h5A);
    // arm window runs out, a late start does nothing
    wr(OFS_CTRL, 8'h04);
    rdChk(OFS_CTRL, 8'h04, 8'h04);
    repeat (2) @(posedge mclk);
    rdChk(OFS_CTRL, 8'h04, 8'h00);
    wr(OFS_CTRL, 8'h02);
    repeat (2) @(posedge mclk);
    rdChk(OFS_CTRL, 8'h02, 8'h00);
    // system reset in mid-program keeps mode and busy
    prog(8'h06, 8'h00, MODE_ERASE);
    pulseReset();
    rdChk(OFS_CTRL, 8'h32, 8'h12);
    waitIdle();
    pulseReset();
    rdChk(OFS_CTRL, 8'hFF, 8'h00);
    fetch(8'h06, ERASED_BYTE);
    // power-on reset is the only way to cut a program short
    prog(8'h07, 8'h11, MODE_ATOMIC);
    porResetn <= 1'b0;
    @(posedge mclk);
    porResetn <= 1'b1;
    rdChk(OFS_CTRL, 8'hFF, 8'h00);
    print_verdict();
  end
endmodule

// file: nvac_checker.sv
`timescale 1ns/1ps
module nvac_checker (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [1:0] ioAddr,
  input wire logic [7:0] ioWdata,
  input wire logic       ioWr,
  input wire logic       ioRd,
  input wire logic [7:0] ioRdata,
  input wire logic       cpuStall,
  input wire logic       readyIrq,
  input wire logic       globalIrqEn
);
  import nvac_pkg::*;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // a refused start or read shows no stall at all, so each stall check allows that
  sequence s_ctrlWr;
    ioWr && ioAddr == OFS_CTRL;
  endsequence
  sequence s_stallProg;
    cpuStall [*2] ##1 !cpuStall;
  endsequence
  sequence s_stallRead;
    cpuStall [*4] ##1 !cpuStall;
  endsequence

  a_prog_stall_two: assert property (s_ctrlWr ##0 ioWdata[BIT_START] |=> s_stallProg or !cpuStall)
    else $error("programming stall is not two cycles");
  a_read_stall_four: assert property (s_ctrlWr ##0 (ioWdata[BIT_READ] && !ioWdata[BIT_START])
    |=> s_stallRead or !cpuStall)
    else $error("read stall is not four cycles");
  a_stall_bounded: assert property ($rose(cpuStall) |-> ##[1:4] !cpuStall)
    else $error("stall lasts too long");
  a_host_holds_off: assert property (cpuStall |-> !ioWr && !ioRd)
    else $error("access issued during stall");
  a_rdata_idle: assert property (!$past(ioRd) |-> ioRdata == RDATA_IDLE)
    else $error("read data outside its cycle");
  a_ctrl_rsvd_zero: assert property (ioRd && ioAddr == OFS_CTRL
    |=> ioRdata[7:6] == 2'h0 && !ioRdata[BIT_READ])
    else $error("control reserved or read bit set");
  a_addr_top_zero: assert property (ioRd && ioAddr == OFS_ADDR |=> !ioRdata[7])
    else $error("address top bit set");
  a_irq_needs_gie: assert property (readyIrq |-> $past(globalIrqEn))
    else $error("ready irq without global enable");
  a_irq_off_busy: assert property (s_ctrlWr ##0 ioWdata[BIT_START] ##1 cpuStall |=> !readyIrq)
    else $error("ready irq while programming");
endmodule

// file: nvac_device.sv
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - 7-bit address, 128 bytes, top bit reads zero
// - software loads address before any access
// - data register: byte to program, byte read
// - mode 00 atomic, 01 erase, 10 write
// - mode writes ignored while programming
// - system reset clears mode unless programming
// - ready interrupt level while idle and enabled
// - arm bit clears itself after four cycles
// - start only counts while arm still set
// - start bit stays until programming time elapses
// - programming start stalls cpu two cycles
// - read fetches at once, stalls four cycles
// - no reads, no address change while busy
// - no new operation accepted while busy
// - erase mode wipes only the addressed byte
// - write-only mode needs a prior erase
// - programming timed by oscillator tick, not cpu
// - software polls start bit before next access
// - control bits 7..6 read zero
// - system reset lets programming finish
module nvac_device #(
  parameter int unsigned TICK_CYCLES  = nvac_pkg::OSC_TICK_CYCLES,
  parameter int unsigned ATOMIC_TICKS = nvac_pkg::PROG_ATOMIC_TICKS,
  parameter int unsigned SPLIT_TICKS  = nvac_pkg::PROG_SPLIT_TICKS
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic porResetn,
  nvac_if.dev       io
);
  import nvac_pkg::*;

  logic [7:0]        mem [NVM_DEPTH];
  logic [NVM_AW-1:0] addr_q;
  logic [7:0]        data_q;
  logic [1:0]        mode_q;
  logic              rie_q;
  logic [2:0]        armCnt_q;
  logic              busy_q;
  logic [1:0]        opMode_q;
  logic [NVM_AW-1:0] opAddr_q;
  logic [7:0]        opData_q;
  logic [TICKW-1:0]  tickDiv_q;
  logic [PROGW-1:0]  progLeft_q;
  logic [2:0]        stallCnt_q;
  logic              stall_q;
  logic              irq_q;
  logic [7:0]        rdata_q;

  logic sysRst;
  logic porRst;
  logic wrAddr;
  logic wrData;
  logic wrCtrl;
  logic armed;
  logic tickEn;
  logic startReq;
  logic readReq;
  logic progDone;

  // one strobe decode shared by every register write
  function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs, input logic stb);
    hit = stb && (a == ofs);
  endfunction

  // power-on reset clears every register but not the store; system reset spares a program in flight
  assign porRst = !porResetn;
  assign sysRst = !resetn || porRst;

  // register strobes
  assign wrAddr = hit(io.ioAddr, OFS_ADDR, io.ioWr);
  assign wrData = hit(io.ioAddr, OFS_DATA, io.ioWr);
  assign wrCtrl = hit(io.ioAddr, OFS_CTRL, io.ioWr);
  assign armed  = (armCnt_q != 3'h0);

  // a start needs the arm window open, an idle store and a defined mode
  assign startReq = wrCtrl && io.ioWdata[BIT_START] && armed && !busy_q
                    && (io.ioWdata[BIT_MODE_H:BIT_MODE_L] != MODE_RSVD || busy_q) // mode of this write if loaded
                    && (mode_q != MODE_RSVD);
  // read is refused while busy; a start in the same write takes priority
  assign readReq  = wrCtrl && io.ioWdata[BIT_READ] && !busy_q && !startReq;

  // oscillator tick and end of programming
  assign tickEn   = (tickDiv_q == TICKW'(TICK_CYCLES - 1));
  assign progDone = busy_q && tickEn && (progLeft_q == PROGW'(1));

  // address register, frozen while programming
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      addr_q <= '0;
    end else if (wrAddr && !busy_q) begin
      addr_q <= io.ioWdata[NVM_AW-1:0];
    end
  end

  // data register: software writes, reads land here immediately
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      data_q <= '0;
    end else if (readReq) begin
      data_q <= mem[addr_q];
    end else if (wrData) begin
      data_q <= io.ioWdata;
    end
  end

  // mode field survives a system reset while the store is busy
  always_ff @(posedge mclk) begin
    if (porRst) begin
      mode_q <= MODE_RESET;
    end else if (!resetn && !busy_q) begin
      mode_q <= MODE_RESET;
    end else if (resetn && wrCtrl && !busy_q) begin
      mode_q <= io.ioWdata[BIT_MODE_H:BIT_MODE_L];
    end
  end

  // ready interrupt enable
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      rie_q <= 1'b0;
    end else if (wrCtrl) begin
      rie_q <= io.ioWdata[BIT_RIE];
    end
  end

  // arm window: opens on a one written while closed, then runs down
  // re-arming an open window does not stretch it, so the window is strict
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      armCnt_q <= 3'h0;
    end else if (wrCtrl && io.ioWdata[BIT_ARM] && !armed) begin
      armCnt_q <= ARM_CYCLES;
    end else if (armed) begin
      armCnt_q <= armCnt_q - 3'h1;
    end
  end

  // busy flag and latched operation; only power-on reset may abort it
  always_ff @(posedge mclk) begin
    if (porRst) begin
      busy_q   <= 1'b0;
      opMode_q <= MODE_ATOMIC;
      opAddr_q <= '0;
      opData_q <= '0;
    end else if (startReq && resetn) begin
      busy_q   <= 1'b1;
      opMode_q <= mode_q;
      opAddr_q <= addr_q;
      opData_q <= data_q;
    end else if (progDone) begin
      busy_q   <= 1'b0;
    end
  end

  // oscillator tick divider, restarted at each start so each tick is whole
  always_ff @(posedge mclk) begin
    if (porRst || startReq || tickEn) begin
      tickDiv_q <= '0;
    end else begin
      tickDiv_q <= tickDiv_q + TICKW'(1);
    end
  end

  // programming time counted in oscillator ticks
  always_ff @(posedge mclk) begin
    if (porRst) begin
      progLeft_q <= '0;
    end else if (startReq && resetn) begin
      progLeft_q <= (mode_q == MODE_ATOMIC) ? PROGW'(ATOMIC_TICKS)
                                            : PROGW'(SPLIT_TICKS);
    end else if (busy_q && tickEn) begin
      progLeft_q <= progLeft_q - PROGW'(1);
    end
  end

  // the cell update happens at the end of the programming time
  // write-only can only clear bits, so an unerased cell ends up corrupt
  always_ff @(posedge mclk) begin
    if (progDone) begin
      unique case (opMode_q)
        MODE_ATOMIC: mem[opAddr_q] <= opData_q;
        MODE_ERASE:  mem[opAddr_q] <= ERASED_BYTE;
        MODE_WRITE:  mem[opAddr_q] <= mem[opAddr_q] & opData_q;
        default:     mem[opAddr_q] <= mem[opAddr_q];
      endcase
    end
  end

  // cpu stall: high for the given number of cycles after the accepting write
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      stallCnt_q <= 3'h0;
      stall_q    <= 1'b0;
    end else if (startReq) begin
      stallCnt_q <= STALL_PROG;
      stall_q    <= 1'b1;
    end else if (readReq) begin
      stallCnt_q <= STALL_READ;
      stall_q    <= 1'b1;
    end else begin
      stallCnt_q <= (stallCnt_q != 3'h0) ? stallCnt_q - 3'h1 : 3'h0;
      stall_q    <= (stallCnt_q > 3'h1);
    end
  end

  // level interrupt while idle; no flag to clear
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= rie_q && io.globalIrqEn && !busy_q;
    end
  end

  // read data one cycle after the strobe; unmapped slot reads zero
  always_ff @(posedge mclk) begin
    if (sysRst || !io.ioRd) begin
      rdata_q <= RDATA_IDLE;
    end else begin
      unique case (io.ioAddr)
        OFS_ADDR: rdata_q <= {1'b0, addr_q};
        OFS_DATA: rdata_q <= data_q;
        OFS_CTRL: rdata_q <= {2'h0, mode_q, rie_q, armed, busy_q, 1'b0};
        default:  rdata_q <= RDATA_IDLE;
      endcase
    end
  end

  assign io.ioRdata  = rdata_q;
  assign io.cpuStall = stall_q;
  assign io.readyIrq = irq_q;

endmodule

// file: nvac_host.sv
`timescale 1ns/1ps
module nvac_host (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [1:0] swAddr,
  input  wire logic [7:0] swWdata,
  input  wire logic       swWr,
  input  wire logic       swRd,
  output logic      [7:0] swRdata,
  output logic            cpuIrq,
  nvac_if.cpu             io
);
  import nvac_pkg::*;

  logic       gie_q;
  logic       drop_q;
  logic       fromDev_q;
  logic [7:0] status_q;
  logic       toDev;
  logic       devWr;
  logic       devRd;
  logic       blocked;

  // device slots pass straight through unless the core is stalled
  assign toDev   = (swAddr != OFS_HOST);
  assign blocked = io.cpuStall;
  assign devWr   = swWr && toDev && !blocked;
  assign devRd   = swRd && toDev && !blocked;

  assign io.ioAddr      = swAddr;
  assign io.ioWdata     = swWdata;
  assign io.ioWr        = devWr;
  assign io.ioRd        = devRd;
  assign io.globalIrqEn = gie_q;

  // global interrupt enable, the core-side gate of the ready interrupt
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gie_q <= 1'b0;
    end else if (swWr && !toDev) begin
      gie_q <= swWdata[HBIT_GIE];
    end
  end

  // sticky drop flag: an access lost to a stall; set wins over clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      drop_q <= 1'b0;
    end else if ((swWr || swRd) && toDev && blocked) begin
      drop_q <= 1'b1;
    end else if (swWr && !toDev && swWdata[HBIT_DROP]) begin
      drop_q <= 1'b0;
    end
  end

  // read answer: device data or own status, always one cycle later
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fromDev_q <= 1'b0;
      status_q  <= 8'h00;
    end else begin
      fromDev_q <= devRd;
      status_q  <= (swRd && !toDev) ? {4'h0, drop_q, io.readyIrq, io.cpuStall, gie_q} : 8'h00;
    end
  end

  // interrupt line to the core, registered
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cpuIrq <= 1'b0;
    end else begin
      cpuIrq <= io.readyIrq;
    end
  end

  // the device already answers in zero when not read, so an OR would also do
  assign swRdata = fromDev_q ? io.ioRdata : status_q;

endmodule

// file: nvac_if.sv
`timescale 1ns/1ps
interface nvac_if;
  logic [1:0] ioAddr;
  logic [7:0] ioWdata;
  logic       ioWr;
  logic       ioRd;
  logic [7:0] ioRdata;
  logic       cpuStall;
  logic       readyIrq;
  logic       globalIrqEn;

  modport dev (
    input  ioAddr,
    input  ioWdata,
    input  ioWr,
    input  ioRd,
    input  globalIrqEn,
    output ioRdata,
    output cpuStall,
    output readyIrq
  );

  modport cpu (
    output ioAddr,
    output ioWdata,
    output ioWr,
    output ioRd,
    output globalIrqEn,
    input  ioRdata,
    input  cpuStall,
    input  readyIrq
  );
endinterface

// file: nvac_pkg.sv
package nvac_pkg;

  // sizes of the data store
  localparam int unsigned NVM_DEPTH  = 128;
  localparam int unsigned NVM_AW     = 7;

  // device register offsets on the I/O register bus
  localparam logic [1:0] OFS_ADDR    = 2'h0;
  localparam logic [1:0] OFS_DATA    = 2'h1;
  localparam logic [1:0] OFS_CTRL    = 2'h2;
  // host-side status/config register (the fourth slot, unused by the device)
  localparam logic [1:0] OFS_HOST    = 2'h3;

  // control register field positions
  localparam int unsigned BIT_READ   = 0;
  localparam int unsigned BIT_START  = 1;
  localparam int unsigned BIT_ARM    = 2;
  localparam int unsigned BIT_RIE    = 3;
  localparam int unsigned BIT_MODE_L = 4;
  localparam int unsigned BIT_MODE_H = 5;

  // host status register field positions
  localparam int unsigned HBIT_GIE   = 0;
  localparam int unsigned HBIT_STALL = 1;
  localparam int unsigned HBIT_IRQ   = 2;
  localparam int unsigned HBIT_DROP  = 3;

  // programming mode codes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE  = 2'h1;
  localparam logic [1:0] MODE_WRITE  = 2'h2;
  localparam logic [1:0] MODE_RSVD   = 2'h3;

  // values after reset and erase
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] RDATA_IDLE  = 8'h00;

  // cycle counts on the cpu clock
  localparam logic [2:0] ARM_CYCLES   = 3'h4;
  localparam logic [2:0] STALL_PROG   = 3'h2;
  localparam logic [2:0] STALL_READ   = 3'h4;

  // programming time base: calibrated oscillator divided to a fixed tick
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned OSC_TICK_NS     = 1000;
  localparam int unsigned OSC_TICK_CYCLES = OSC_TICK_NS / CLK_PERIOD_NS;
  localparam real         PROG_ATOMIC_MS  = 3.4;
  localparam real         PROG_SPLIT_MS   = 1.8;
  localparam int unsigned PROG_ATOMIC_TICKS = int'(PROG_ATOMIC_MS * 1.0e6 / OSC_TICK_NS);
  localparam int unsigned PROG_SPLIT_TICKS  = int'(PROG_SPLIT_MS * 1.0e6 / OSC_TICK_NS);
  localparam int unsigned TICKW = 12;
  localparam int unsigned PROGW = 16;

endpackage
